/* File: logic/stc_cfg_if.sv */
// Configuration fields passed from the register block to the timing unit.
// Driven by the register block only; the timing unit reads them.
`timescale 1ns/100ps
interface stc_cfg_if;
  logic [2:0] mode;
  logic       ss_en;
  logic [3:0] chip_period_code;

  modport owner  (output mode, output ss_en, output chip_period_code);
  modport timing (input mode, input ss_en, input chip_period_code);
endinterface

/* File: logic/stc_latency_timing.sv */
// Sample-latency reference selection and chip/bit-time enable generator.
// Assumes all strobes are one-cycle pulses synchronous to i_mclk.
`timescale 1ns/100ps
module stc_latency_timing
  import stc_pkg::*;
#(
  parameter int NSRC = 8
)(
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  // Configuration
  stc_cfg_if.timing              cfg,
  // Latency reference events
  input  wire logic              i_periodic_response_start,
  input  wire logic              i_dsi_cmd_fall,
  input  wire logic              i_psi_slot_start,
  input  wire logic              i_psi_sync,
  input  wire logic              i_spi_cs_fall,
  input  wire logic [2:0]        i_source_slot_id,
  input  wire logic [NSRC-1:0]   i_source_enable,
  input  wire logic              i_i2c_data_read,
  // Response transmission
  input  wire logic              i_pdcm_active,
  input  wire logic              i_tx_start,
  input  wire logic              i_tx_active,
  // Results
  output logic                   o_sample_strobe,
  output logic [NSRC-1:0]        o_sample_mask,
  output logic                   o_chip_tick,
  output logic                   o_slew_enable
);

  typedef struct packed {
    logic            strobe;
    logic [NSRC-1:0] mask;
    logic            tick;
    logic            slew;
    logic [15:0]     cnt;
  } stc_lt_state_t;

  stc_lt_state_t st_r;
  stc_lt_state_t st_nxt;

  logic [NSRC-1:0] lowest;
  logic [15:0]     period;
  logic            timed;

  always_comb
  begin
    st_nxt = st_r;
    lowest = '0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (i_source_enable[i])
        lowest = NSRC'(1) << i;
    st_nxt.strobe = 1'b0;
    st_nxt.mask   = '0;
    unique case (cfg.mode)
      STC_MODE_DSI3:
      begin
        st_nxt.strobe = cfg.ss_en ? i_dsi_cmd_fall     // R8
                                  : i_periodic_response_start; // R7
        st_nxt.mask   = i_source_enable;
      end
      STC_MODE_PSI5, STC_MODE_PSI5_PROG:
      begin
        st_nxt.strobe = cfg.ss_en ? i_psi_sync          // R10
                                  : i_psi_slot_start;   // R9
        st_nxt.mask   = i_source_enable;
      end
      STC_MODE_SPI:
      begin
        if (i_spi_cs_fall && !cfg.ss_en)
        begin
          st_nxt.strobe = 1'b1;
          st_nxt.mask   = (NSRC'(1) << i_source_slot_id)
                          & i_source_enable; // R11
        end
        else if (i_spi_cs_fall
                 && ((NSRC'(1) << i_source_slot_id) == lowest))
        begin
          // Others stay stale until the lowest slot is asked for
          st_nxt.strobe = 1'b1; // R12 R13
          st_nxt.mask   = i_source_enable; // R14
        end
      end
      default:
      begin
        // Sampling selection is stored but has no effect here
        st_nxt.strobe = i_i2c_data_read; // R16
        st_nxt.mask   = i_source_enable;
      end
    endcase
    if (!st_nxt.strobe)
      st_nxt.mask = '0;

    timed  = 1'b1;
    period = stc_cycles(STC_CRM_CHIP_NS);
    st_nxt.slew = 1'b1;
    unique case (cfg.mode)
      STC_MODE_DSI3:
        if (i_pdcm_active)
        begin
          period      = stc_cycles(stc_dsi_chip_ns(cfg.chip_period_code));
          st_nxt.slew = cfg.chip_period_code >= STC_DSI_SLEW_MIN_CODE;
        end // R18
      STC_MODE_PSI5, STC_MODE_PSI5_PROG:
        period = cfg.chip_period_code[3] ? stc_cycles(STC_PSI_SLOW_NS)
                                         : stc_cycles(STC_PSI_FAST_NS); // R17
      default:
      begin
        timed       = 1'b0; // R19
        st_nxt.slew = 1'b0;
      end
    endcase

    st_nxt.tick = 1'b0;
    if (i_tx_start || !i_tx_active || !timed)
      st_nxt.cnt = '0;
    else if (st_r.cnt == period - 16'h0001)
    begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end
    else
      st_nxt.cnt = st_r.cnt + 16'h0001;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_sample_strobe = st_r.strobe;
  assign o_sample_mask   = st_r.mask;
  assign o_chip_tick     = st_r.tick;
  assign o_slew_enable   = st_r.slew;

endmodule

/* File: logic/stc_pkg.sv */
// Shared constants for the chip-time and sampling configuration block.
// Assumes a single 200 MHz clock and the register map of the sensor core.
package stc_pkg;

  // Register map
  localparam logic [7:0] STC_CFG_ADDR  = 8'h23;
  localparam logic [7:0] STC_CFG_RESET = 8'h00;

  // Field positions inside the configuration byte
  localparam int STC_TOP_BIT_POS    = 7;
  localparam int STC_REPEAT_LSB     = 5;
  localparam int STC_FAULT_LATCH_POS = 4;
  localparam int STC_SS_EN_POS      = 4;
  localparam int STC_CHIP_LSB       = 0;

  // Communication modes
  localparam logic [2:0] STC_MODE_DSI3      = 3'h0;
  localparam logic [2:0] STC_MODE_PSI5      = 3'h1;
  localparam logic [2:0] STC_MODE_PSI5_PROG = 3'h2;
  localparam logic [2:0] STC_MODE_SPI       = 3'h3;
  localparam logic [2:0] STC_MODE_I2C       = 3'h4;

  // Timing
  localparam int STC_CLK_MHZ      = 200;
  localparam int STC_CLK_NS       = 1000 / STC_CLK_MHZ;
  localparam int STC_CRM_CHIP_NS  = 5000;
  localparam int STC_PSI_FAST_NS  = 5300;
  localparam int STC_PSI_SLOW_NS  = 8000;
  localparam logic [3:0] STC_DSI_SLEW_MIN_CODE = 4'h2;

  // Repetition limit of the startup self-test
  function automatic logic [3:0] stc_repeat_limit(input logic [1:0] code);
    unique case (code)
      2'h0:    stc_repeat_limit = 4'h8;
      2'h1:    stc_repeat_limit = 4'h1;
      2'h2:    stc_repeat_limit = 4'h4;
      default: stc_repeat_limit = 4'h2;
    endcase
  endfunction

  // Periodic-collection chip time in ns
  function automatic int stc_dsi_chip_ns(input logic [3:0] code);
    unique case (code)
      4'h0:    stc_dsi_chip_ns = 1000;
      4'h1:    stc_dsi_chip_ns = 2000;
      4'h2:    stc_dsi_chip_ns = 2500;
      4'h3:    stc_dsi_chip_ns = 2600;
      4'h4:    stc_dsi_chip_ns = 2600;
      4'h5:    stc_dsi_chip_ns = 2700;
      4'h6:    stc_dsi_chip_ns = 2800;
      4'h7:    stc_dsi_chip_ns = 2900;
      4'h8:    stc_dsi_chip_ns = 3000;
      4'h9:    stc_dsi_chip_ns = 3100;
      4'hA:    stc_dsi_chip_ns = 3200;
      4'hB:    stc_dsi_chip_ns = 3300;
      4'hC:    stc_dsi_chip_ns = 3500;
      4'hD:    stc_dsi_chip_ns = 4000;
      4'hE:    stc_dsi_chip_ns = 4500;
      default: stc_dsi_chip_ns = 5000;
    endcase
  endfunction

  // Whole clock cycles in a time given in ns
  function automatic logic [15:0] stc_cycles(input int ns);
    stc_cycles = 16'(ns / STC_CLK_NS);
  endfunction

endpackage

/* File: logic/stc_sample_timing_cfg.sv */
// Chip-time and sampling configuration register with its control logic:
// register access, integrity shadow, self-test repetition and fault latch.
// Assumes a simple synchronous register port from the active serial link.
`timescale 1ns/100ps

// Function
// R1 - Register is readable and writable in DSI3, SPI, I2C, PSI5 programming
// R2 - Register contents are covered by the read/write array integrity check
// R3 - PSI5 repeat code 00/01/10/11 allows 8/1/4/2 self-test runs
// R4 - Self-test fail flag sets only after the selected runs all fail
// R5 - PSI5 with fault latch set holds every fault until reset
// R6 - PSI5 with fault latch clear uses normal automatic fault clearing
// R7 - DSI3 synchronous sampling: latency from periodic response start
// R8 - DSI3 simultaneous sampling: latency from collection command falling edge
// R9 - PSI5 synchronous sampling: latency referenced to the assigned time slot
// R10 - PSI5 simultaneous sampling: latency referenced to the sync pulse
// R11 - SPI synchronous: each slot referenced to its own request select edge
// R12 - SPI simultaneous: all slots referenced to slot zero request edge
// R13 - If slot zero disabled, lowest enabled slot becomes common reference
// R14 - Higher slots update only when lowest enabled slot is requested
// R15 - Host should include lowest enabled slot requests to keep data fresh
// R16 - In I2C the sampling bit is stored and read but changes nothing
// R17 - PSI5 bit time: codes 0-7 give 189 kHz, 8-15 give 125 kHz
// R18 - DSI3 code applies to periodic collection; other traffic 5 us slewed
// R19 - In SPI and I2C the chip code is stored and read only
module stc_sample_timing_cfg
  import stc_pkg::*;
#(
  parameter int NSRC   = 8,
  parameter int NFAULT = 8
)(
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  // Operating mode
  input  wire logic [2:0]        i_comm_mode,
  // Register port
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_wdata,
  output logic [7:0]             o_reg_rdata,
  output logic                   o_reg_hit,
  // Integrity check
  output logic                   o_cfg_parity,
  output logic                   o_integrity_err,
  // Self-test
  input  wire logic              i_selftest_start,
  input  wire logic              i_selftest_done,
  input  wire logic              i_selftest_pass,
  output logic                   o_selftest_run,
  output logic                   o_selftest_busy,
  output logic                   o_selftest_fail_flag,
  output logic [3:0]             o_selftest_count,
  // Internal faults
  input  wire logic [NFAULT-1:0] i_fault_set,
  input  wire logic [NFAULT-1:0] i_fault_autoclr,
  output logic [NFAULT-1:0]      o_fault_flags,
  // Latency reference events
  input  wire logic              i_periodic_response_start,
  input  wire logic              i_dsi_cmd_fall,
  input  wire logic              i_psi_slot_start,
  input  wire logic              i_psi_sync,
  input  wire logic              i_spi_cs_fall,
  input  wire logic [2:0]        i_source_slot_id,
  input  wire logic [NSRC-1:0]   i_source_enable,
  input  wire logic              i_i2c_data_read,
  // Response transmission
  input  wire logic              i_pdcm_active,
  input  wire logic              i_tx_start,
  input  wire logic              i_tx_active,
  // Sampling and timing outputs
  output logic                   o_sample_strobe,
  output logic [NSRC-1:0]        o_sample_mask,
  output logic                   o_chip_tick,
  output logic                   o_slew_enable,
  // Decoded configuration
  output logic                   o_selftest_top_bit,
  output logic [1:0]             o_selftest_repeat_limit,
  output logic                   o_ss_en,
  output logic [3:0]             o_chip_period_code
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DONE
  } stc_st_state_t;

  typedef struct packed {
    logic [7:0]        cfg;
    logic [7:0]        shadow;
    logic [7:0]        rdata;
    logic              hit;
    logic              ierr;
    stc_st_state_t     st;
    logic [3:0]        count;
    logic              run;
    logic              fail;
    logic [NFAULT-1:0] faults;
  } stc_state_t;

  stc_state_t s_r;
  stc_state_t s_nxt;

  logic psi5;
  logic access_ok;
  logic addr_hit;
  logic latch_on;
  logic [3:0] limit;

  stc_cfg_if cfg_bus ();

  assign psi5      = (i_comm_mode == STC_MODE_PSI5)
                     || (i_comm_mode == STC_MODE_PSI5_PROG);
  // Normal PSI5 runs from the stored image; no host can reach it then
  assign access_ok = (i_comm_mode == STC_MODE_DSI3)
                     || (i_comm_mode == STC_MODE_SPI)
                     || (i_comm_mode == STC_MODE_I2C)
                     || (i_comm_mode == STC_MODE_PSI5_PROG); // R1
  assign addr_hit  = access_ok && (i_reg_addr == STC_CFG_ADDR);
  assign latch_on  = s_r.cfg[STC_FAULT_LATCH_POS];
  assign limit     = stc_repeat_limit(
                       s_r.cfg[STC_REPEAT_LSB +: 2]); // R3

  always_comb
  begin
    s_nxt = s_r;

    // Register access
    s_nxt.hit = 1'b0;
    if (i_reg_wr && addr_hit)
    begin
      s_nxt.cfg    = i_reg_wdata; // R1 R16 R19
      s_nxt.shadow = ~i_reg_wdata; // R2
    end
    if (i_reg_rd && addr_hit)
    begin
      s_nxt.rdata = s_r.cfg; // R1
      s_nxt.hit   = 1'b1;
    end
    else if (i_reg_rd)
      s_nxt.rdata = 8'h00;

    // Complement shadow catches upsets in either copy
    s_nxt.ierr = s_r.ierr || (s_r.cfg != ~s_r.shadow); // R2

    // Startup self-test repetition
    s_nxt.run = 1'b0;
    unique case (s_r.st)
      ST_IDLE:
        if (i_selftest_start && psi5)
        begin
          s_nxt.count = 4'h0;
          s_nxt.run   = 1'b1;
          s_nxt.st    = ST_WAIT;
        end
      ST_WAIT:
        if (i_selftest_done)
        begin
          if (i_selftest_pass)
            s_nxt.st = ST_DONE;
          else if (s_r.count + 4'h1 >= limit)
          begin
            s_nxt.count = s_r.count + 4'h1;
            s_nxt.fail  = 1'b1; // R4
            s_nxt.st    = ST_DONE;
          end
          else
          begin
            s_nxt.count = s_r.count + 4'h1;
            s_nxt.run   = 1'b1; // R3
          end
        end
      ST_DONE:
        if (i_selftest_start && psi5)
        begin
          s_nxt.count = 4'h0;
          s_nxt.run   = 1'b1;
          s_nxt.st    = ST_WAIT;
        end
    endcase

    // Fault flags: a new fault beats a clear in the same cycle
    if (psi5 && latch_on)
      s_nxt.faults = s_r.faults | i_fault_set; // R5
    else
      s_nxt.faults = (s_r.faults & ~i_fault_autoclr) | i_fault_set; // R6
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_r        <= '0;
      s_r.cfg    <= STC_CFG_RESET;
      s_r.shadow <= ~STC_CFG_RESET;
      s_r.st     <= ST_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign cfg_bus.mode             = i_comm_mode;
  assign cfg_bus.ss_en            = s_r.cfg[STC_SS_EN_POS];
  assign cfg_bus.chip_period_code = s_r.cfg[STC_CHIP_LSB +: 4];

  stc_latency_timing #(
    .NSRC (NSRC)
  ) u_timing (
    .i_mclk                    (i_mclk),
    .i_rst_n                   (i_rst_n),
    .cfg                       (cfg_bus),
    .i_periodic_response_start (i_periodic_response_start),
    .i_dsi_cmd_fall            (i_dsi_cmd_fall),
    .i_psi_slot_start          (i_psi_slot_start),
    .i_psi_sync                (i_psi_sync),
    .i_spi_cs_fall             (i_spi_cs_fall),
    .i_source_slot_id          (i_source_slot_id),
    .i_source_enable           (i_source_enable),
    .i_i2c_data_read           (i_i2c_data_read),
    .i_pdcm_active             (i_pdcm_active),
    .i_tx_start                (i_tx_start),
    .i_tx_active               (i_tx_active),
    .o_sample_strobe           (o_sample_strobe),
    .o_sample_mask             (o_sample_mask),
    .o_chip_tick               (o_chip_tick),
    .o_slew_enable             (o_slew_enable)
  );

  assign o_reg_rdata             = s_r.rdata;
  assign o_reg_hit               = s_r.hit;
  assign o_cfg_parity            = ^s_r.cfg; // R2
  assign o_integrity_err         = s_r.ierr;
  assign o_selftest_run          = s_r.run;
  assign o_selftest_busy         = (s_r.st == ST_WAIT);
  assign o_selftest_fail_flag    = s_r.fail;
  assign o_selftest_count        = s_r.count;
  assign o_fault_flags           = s_r.faults;
  assign o_selftest_top_bit      = s_r.cfg[STC_TOP_BIT_POS];
  assign o_selftest_repeat_limit = s_r.cfg[STC_REPEAT_LSB +: 2];
  assign o_ss_en                 = s_r.cfg[STC_SS_EN_POS];
  assign o_chip_period_code      = s_r.cfg[STC_CHIP_LSB +: 4];

endmodule

/* File: tb/stc_sample_timing_cfg_bench.sv */
// Self-checking bench for the chip-time and sampling configuration block.
// Assumes the self-test model answers runs; one 200 MHz clock.
`timescale 1ns/100ps
module stc_sample_timing_cfg_bench;
  import stc_pkg::*;
  logic i_mclk, i_rst_n, i_reg_wr, i_reg_rd, i_selftest_start;
  logic i_selftest_done, i_selftest_pass, i_periodic_response_start;
  logic i_dsi_cmd_fall, i_psi_slot_start, i_psi_sync, i_spi_cs_fall;
  logic i_i2c_data_read, i_pdcm_active, i_tx_start, i_tx_active;
  logic o_reg_hit, o_cfg_parity, o_integrity_err, o_selftest_run;
  logic o_selftest_busy, o_selftest_fail_flag, o_sample_strobe;
  logic o_chip_tick, o_slew_enable, o_selftest_top_bit, o_ss_en;
  logic [2:0] i_comm_mode, i_source_slot_id;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_sample_mask;
  logic [7:0] i_fault_set, i_fault_autoclr, o_fault_flags, i_source_enable;
  logic [3:0] o_selftest_count, o_chip_period_code, pass_run, dly;
  logic [1:0] o_selftest_repeat_limit;
  logic [5:0] ev;
  logic [8:0] snap;
  logic [7:0] d, prev, f, g, en, rq[$], sq[$];
  logic [15:0] lf = 16'h01AB;
  int n_errors, comparisons, low, n;
  int sel[6] = '{5, 4, 3, 2, 0, 0};
  int lim[4] = '{8, 1, 4, 2};
  int per[5] = '{1000 / STC_CLK_NS, STC_CRM_CHIP_NS / STC_CLK_NS,
                 STC_PSI_FAST_NS / STC_CLK_NS, STC_PSI_SLOW_NS / STC_CLK_NS,
                 1700};
  assign {i_periodic_response_start, i_dsi_cmd_fall, i_psi_slot_start,
          i_psi_sync, i_spi_cs_fall, i_i2c_data_read} = ev;

  stc_sample_timing_cfg #(.NSRC(8), .NFAULT(8)) dut_u (.*);
  stc_selftest_model st_u (.i_mclk, .i_rst_n, .i_run(o_selftest_run),
    .i_pass_run(pass_run), .i_delay(dly), .o_done(i_selftest_done),
    .o_pass(i_selftest_pass));

  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k = 1);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] x);
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {w, !w, a, x};
    tick();
    snap = {o_reg_hit, o_reg_rdata};
    {i_reg_wr, i_reg_rd} = 2'b00;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    if (h)
      rq.push_back(e);
    op(1'b0, a, 8'h00);
    if (!h)
      chk(snap, 9'h000);
  endtask
  // PSI5 refuses writes, so its settings go in through programming mode
  task automatic set_cfg(input logic [2:0] m, input logic [7:0] x);
    i_comm_mode = (m == STC_MODE_PSI5) ? STC_MODE_PSI5_PROG : m;
    op(1'b1, STC_CFG_ADDR, x);
    i_comm_mode = m;
  endtask
  task automatic pulse(input logic [5:0] e);
    ev = e;
    tick();
    ev = 6'h00;
    tick();
  endtask
  task automatic do_reset();
    i_rst_n = 1'b0;
    tick(3);
    i_rst_n = 1'b1;
  endtask
  task automatic close_out();
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  always @(negedge i_mclk)
  begin
    if (o_reg_hit !== 1'b0)
      chk(o_reg_rdata, rq.size() ? rq.pop_front() : 8'hXX);
    if (o_sample_strobe !== 1'b0)
      chk(o_sample_mask, sq.size() ? sq.pop_front() : 8'hXX);
  end
  initial
  begin
    #(60000 * 5);
    n_errors++;
    close_out();
  end

  initial
  begin
    {i_reg_wr, i_reg_rd, i_selftest_start, i_pdcm_active, i_tx_start} = '0;
    {i_tx_active, ev, i_comm_mode, i_source_slot_id, i_reg_addr} = '0;
    {i_reg_wdata, i_fault_set, i_fault_autoclr, pass_run, dly} = '0;
    i_source_enable = 8'hFF;
    do_reset();
    rd(STC_CFG_ADDR, STC_CFG_RESET, 1'b1);
    prev = STC_CFG_RESET;
    for (int m = 0; m < 5; m++)
    begin
      i_comm_mode = 3'(m);
      d = rnd();
      op(1'b1, STC_CFG_ADDR, d);
      if (m == 1)
        d = prev;
      chk({o_selftest_top_bit, o_selftest_repeat_limit, o_ss_en,
           o_chip_period_code}, d);
      chk(o_cfg_parity, ^d);
      rd(STC_CFG_ADDR, d, m != 1);
      rd(8'h24, 8'h00, 1'b0);
      prev = d;
    end
    chk(o_integrity_err, 1'b0);
    // Each limit code fails out, then a pass on run two
    for (int k = 0; k < 5; k++)
    begin
      do_reset();
      pass_run = (k == 4) ? 4'h2 : 4'h0;
      dly = 4'(rnd());
      set_cfg(STC_MODE_PSI5, {1'b0, 2'(k), 5'h00});
      i_selftest_start = 1'b1;
      tick();
      i_selftest_start = 1'b0;
      for (int t = 0; t < 400 && o_selftest_busy === 1'b1; t++)
        tick();
      chk(o_selftest_fail_flag, k != 4);
      chk(o_selftest_count, (k == 4) ? 1 : lim[k]);
    end
    for (int k = 0; k < 2; k++)
    begin
      set_cfg(STC_MODE_PSI5, {3'h0, 1'(k), 4'h0});
      f = rnd();
      i_fault_set = f;
      tick();
      i_fault_set = 8'h00;
      g = o_fault_flags;
      chk(g & f, f);
      i_fault_autoclr = 8'hFF;
      tick();
      i_fault_autoclr = 8'h00;
      chk(o_fault_flags, k ? g : 8'h00);
    end
    for (int c = 0; c < 6; c++)
    begin
      i_source_enable = rnd() | 8'h01;
      set_cfg((c < 2) ? STC_MODE_DSI3 : (c < 4) ? STC_MODE_PSI5 : STC_MODE_I2C,
              {3'h0, 1'(c), 4'h0});
      for (int b = 0; b < 6; b++)
      begin
        if (b == sel[c])
          sq.push_back(i_source_enable);
        pulse(6'(1 << b));
      end
    end
    set_cfg(STC_MODE_SPI, 8'h00);
    i_source_enable = rnd();
    for (int id = 0; id < 8; id++)
      if (i_source_enable[id])
      begin
        sq.push_back(8'h01 << id);
        i_source_slot_id = 3'(id);
        pulse(6'h02);
      end
    // Requests include the lowest enabled slot so the others stay current
    for (int k = 0; k < 2; k++)
    begin
      en = k ? ((rnd() & 8'hFE) | 8'h80) : (rnd() | 8'h01);
      i_source_enable = en;
      set_cfg(STC_MODE_SPI, 8'h10);
      low = 8;
      for (int j = 7; j >= 0; j--)
        if (en[j])
          low = j;
      for (int id = 0; id < 8; id++)
        if (en[id])
        begin
          if (id == low)
            sq.push_back(en);
          i_source_slot_id = 3'(id);
          pulse(6'h02);
        end
    end
    for (int e = 0; e < 5; e++)
    begin
      i_pdcm_active = (e == 0);
      set_cfg((e < 2) ? STC_MODE_DSI3 : (e < 4) ? STC_MODE_PSI5 : STC_MODE_SPI,
              (e == 2) ? 8'h07 : (e == 3) ? 8'h08 : 8'h00);
      {i_tx_start, i_tx_active} = 2'b11;
      tick();
      i_tx_start = 1'b0;
      n = 0;
      while (o_chip_tick !== 1'b1 && n < 1700)
      begin
        tick();
        n++;
      end
      i_tx_active = 1'b0;
      chk(16'(n), 16'(per[e]));
      chk(o_slew_enable, e == 1 || e == 2 || e == 3);
    end
    tick(4);
    chk(16'(rq.size() + sq.size()), 16'h0000);
    close_out();
  end
endmodule

/* File: tb/stc_sample_timing_cfg_sva.sv */
// Port assertions for the configuration block.
// Bound to every instance; single clock domain.
`timescale 1ns/100ps
module stc_cfg_sva
  import stc_pkg::*;
#(
  parameter int NSRC   = 8,
  parameter int NFAULT = 8
)(
  input wire logic              i_mclk,
  input wire logic              i_rst_n,
  input wire logic [2:0]        i_comm_mode,
  input wire logic [7:0]        i_reg_addr,
  input wire logic              i_reg_wr,
  input wire logic              i_reg_rd,
  input wire logic [7:0]        i_reg_wdata,
  input wire logic [7:0]        o_reg_rdata,
  input wire logic              o_reg_hit,
  input wire logic              o_cfg_parity,
  input wire logic              i_selftest_start,
  input wire logic              i_selftest_done,
  input wire logic              i_selftest_pass,
  input wire logic              o_selftest_run,
  input wire logic              o_selftest_busy,
  input wire logic              o_selftest_fail_flag,
  input wire logic [NFAULT-1:0] i_fault_set,
  input wire logic [NFAULT-1:0] i_fault_autoclr,
  input wire logic [NFAULT-1:0] o_fault_flags,
  input wire logic              i_periodic_response_start,
  input wire logic              i_psi_sync,
  input wire logic              i_pdcm_active,
  input wire logic              o_sample_strobe,
  input wire logic              o_slew_enable,
  input wire logic              o_selftest_top_bit,
  input wire logic [1:0]        o_selftest_repeat_limit,
  input wire logic              o_ss_en,
  input wire logic [3:0]        o_chip_period_code
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  wire logic [7:0] cfg = {o_selftest_top_bit, o_selftest_repeat_limit,
                          o_ss_en, o_chip_period_code};
  wire logic psi = i_comm_mode inside {STC_MODE_PSI5, STC_MODE_PSI5_PROG};

  sequence s_go;
    i_selftest_start && psi && !o_selftest_busy;
  endsequence
  sequence s_last_fail;
    o_selftest_busy && i_selftest_done && !i_selftest_pass
      && o_selftest_repeat_limit == 2'h1;
  endsequence

  property p_wr;
    i_reg_wr && i_reg_addr == STC_CFG_ADDR && i_comm_mode != STC_MODE_PSI5
      |=> cfg == $past(i_reg_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("write not stored");
  property p_ref;
    i_reg_rd && i_comm_mode == STC_MODE_PSI5 |=> !o_reg_hit && o_reg_rdata == 8'h00;
  endproperty
  a_ref: assert property (p_ref) else $error("refused read answered");
  property p_par;
    o_cfg_parity == ^cfg;
  endproperty
  a_par: assert property (p_par) else $error("parity wrong");
  property p_go;
    s_go |=> o_selftest_run && o_selftest_busy;
  endproperty
  a_go: assert property (p_go) else $error("no run after start");
  property p_lim;
    s_last_fail |=> o_selftest_fail_flag ##1 o_selftest_fail_flag;
  endproperty
  a_lim: assert property (p_lim) else $error("fail flag missing");
  property p_rise;
    $rose(o_selftest_fail_flag)
      |-> $past(i_selftest_done) && !$past(i_selftest_pass);
  endproperty
  a_rise: assert property (p_rise) else $error("fail flag early");
  property p_latch;
    psi && o_ss_en && o_fault_flags != '0
      |=> (o_fault_flags & $past(o_fault_flags)) == $past(o_fault_flags);
  endproperty
  a_latch: assert property (p_latch) else $error("latched fault lost");
  property p_clr;
    !o_ss_en && i_fault_autoclr[0] && !i_fault_set[0] |=> !o_fault_flags[0];
  endproperty
  a_clr: assert property (p_clr) else $error("fault not cleared");
  property p_dsi;
    i_comm_mode == STC_MODE_DSI3 && !o_ss_en && i_periodic_response_start
      |=> o_sample_strobe;
  endproperty
  a_dsi: assert property (p_dsi) else $error("no strobe on start");
  property p_psi;
    i_comm_mode == STC_MODE_PSI5 && o_ss_en && i_psi_sync |=> o_sample_strobe;
  endproperty
  a_psi: assert property (p_psi) else $error("no strobe on sync");
  property p_slew;
    i_comm_mode == STC_MODE_DSI3 && !i_pdcm_active |=> o_slew_enable;
  endproperty
  a_slew: assert property (p_slew) else $error("slew off in command");
endmodule

bind stc_sample_timing_cfg stc_cfg_sva #(.NSRC(NSRC), .NFAULT(NFAULT)) u_sva (
  .i_mclk, .i_rst_n, .i_comm_mode, .i_reg_addr, .i_reg_wr, .i_reg_rd,
  .i_reg_wdata, .o_reg_rdata, .o_reg_hit, .o_cfg_parity, .i_selftest_start,
  .i_selftest_done, .i_selftest_pass, .o_selftest_run, .o_selftest_busy,
  .o_selftest_fail_flag, .i_fault_set, .i_fault_autoclr, .o_fault_flags,
  .i_periodic_response_start, .i_psi_sync, .i_pdcm_active, .o_sample_strobe,
  .o_slew_enable, .o_selftest_top_bit, .o_selftest_repeat_limit, .o_ss_en,
  .o_chip_period_code);

/* File: tb/stc_selftest_model.sv */
// Self-test engine at the far side: answers each run request.
// Assumes one-cycle run pulses; answer delay and passing run set by bench.
`timescale 1ns/100ps
module stc_selftest_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic [3:0] i_pass_run,
  input  wire logic [3:0] i_delay,
  output logic            o_done,
  output logic            o_pass
);
  logic [3:0] runs_r;
  logic [4:0] wait_r;

  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      runs_r <= 4'h0;
      wait_r <= 5'h00;
      o_done <= 1'b0;
      o_pass <= 1'b1;
    end
    else
    begin
      o_done <= (wait_r == 5'h01);
      // Result is only valid with done; toggle it otherwise
      o_pass <= (wait_r == 5'h01) ? (runs_r == i_pass_run) : ~o_pass;
      if (i_run)
      begin
        runs_r <= runs_r + 4'h1;
        wait_r <= {1'b0, i_delay} + 5'h02;
      end
      else if (wait_r != 5'h00)
        wait_r <= wait_r - 5'h01;
    end
endmodule
